// *** core/dbesc_defines.vh ***
// constants for the dc bus energy saving controller
// assumes a 40 mhz control clock; times are held in seconds
// Function
// - saving state reported, dc bus charge dropped
// - run request exits saving, charges, then runs
// - bus uncharged at exit timeout raises error
// - mode from delay and input configuration
// - delay configured: power on straight into saving
// - motor stop starts delay, then saving
// - manual mode: power on charges the bus
// - rising edge enters saving if stopped, idle
// - falling edge in saving returns to normal
// - run after recharge starts with no delay
// - rising edge during delay enters saving early
// - falling edge during delay ignored
// - delay disabled or 0 to 32400 s
// - mains contactor forces delay and input off
// - input from digital inputs or command bits
// - command bits 1 to 10 need io profile
// - exit timeout 1 to 999 s, reset 5 s
// - run held off up to exit timeout
`ifndef DBESC_DEFINES_VH
`define DBESC_DEFINES_VH
`define DBESC_CLK_HZ        26'h2625a00
`define DBESC_DELAY_MAX_S   15'h7e90
`define DBESC_TMO_MIN_S     10'h001
`define DBESC_TMO_MAX_S     10'h3e7
`define DBESC_TMO_RST_S     10'h005
`define DBESC_NUM_DI        6
`define DBESC_NUM_WORDS     5
// input select: 0 none, 1..6 digital input, 8+16*w+b command word w bit b
`define DBESC_SEL_NONE      7'h00
`define DBESC_SEL_CMD_BASE  7'h08
`endif

// *** core/dbesc_sec_tick.v ***
// one pulse per second from the control clock
// assumes the synchronised active low reset of the top
`timescale 1ns/1ps
`include "dbesc_defines.vh"
module dbesc_sec_tick (
	input  wire i_ref_clk,
	input  wire i_rst_n,
	input  wire i_clear,
	output reg  o_tick
);
	localparam [25:0] LAST = `DBESC_CLK_HZ - 26'h0000001;
	reg [25:0] count;
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count  <= 26'h0000000;
			o_tick <= 1'b0;
		end else if (i_clear || count == LAST) begin
			count  <= 26'h0000000;
			o_tick <= !i_clear;
		end else begin
			count  <= count + 26'h0000001;
			o_tick <= 1'b0;
		end
	end
endmodule // dbesc_sec_tick

// *** core/dbesc_ctrl.v ***
// dc bus energy saving controller
// assumes all inputs synchronous to i_ref_clk; config stable while used
`timescale 1ns/1ps
`include "dbesc_defines.vh"
module dbesc_ctrl (
	input  wire        i_ref_clk,
	input  wire        i_nrst,
	input  wire        i_delay_en,
	input  wire [14:0] i_delay_s,
	input  wire [6:0]  i_saving_input_select,
	input  wire [9:0]  i_exit_timeout_s,
	input  wire        i_mains_contactor_assigned,
	input  wire        i_io_profile,
	input  wire [5:0]  i_physical_digital_input,
	input  wire [74:0] i_cmd_words,
	input  wire        i_motor_stopped,
	input  wire        i_run_request,
	input  wire        i_bus_charged,
	output reg         o_energy_saving,
	output reg         o_bus_charge_en,
	output reg         o_run_enable,
	output reg         o_exit_error,
	output reg  [1:0]  o_mode
);
	localparam [1:0] MODE_OFF    = 2'h0;
	localparam [1:0] MODE_AUTO   = 2'h1;
	localparam [1:0] MODE_MANUAL = 2'h2;
	localparam [1:0] MODE_SEMI   = 2'h3;
	localparam [4:0] ST_INIT   = 5'h01;
	localparam [4:0] ST_NORMAL = 5'h02;
	localparam [4:0] ST_DELAY  = 5'h04;
	localparam [4:0] ST_SAVING = 5'h08;
	localparam [4:0] ST_EXIT   = 5'h10;

	reg        rst_meta;
	reg        rst_n;
	always @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// effective configuration
	wire        delay_on = i_delay_en && !i_mains_contactor_assigned;
	wire [14:0] delay_lim = (i_delay_s > `DBESC_DELAY_MAX_S) ? `DBESC_DELAY_MAX_S
		: i_delay_s;
	wire [9:0]  tmo_lim = (i_exit_timeout_s < `DBESC_TMO_MIN_S) ? `DBESC_TMO_MIN_S
		: (i_exit_timeout_s > `DBESC_TMO_MAX_S) ? `DBESC_TMO_MAX_S
		: i_exit_timeout_s;

	// input selection
	wire [6:0] cmd_idx = i_saving_input_select - `DBESC_SEL_CMD_BASE;
	wire [2:0] cmd_word = cmd_idx[6:4];
	wire [3:0] cmd_bit = cmd_idx[3:0];
	reg        sel_valid;
	reg        sel_level;
	always @* begin
		sel_valid = 1'b0;
		sel_level = 1'b0;
		if (i_saving_input_select != `DBESC_SEL_NONE
				&& i_saving_input_select <= `DBESC_NUM_DI) begin
			sel_valid = 1'b1;
			sel_level = i_physical_digital_input[i_saving_input_select[2:0] - 3'h1];
		end else if (i_saving_input_select >= `DBESC_SEL_CMD_BASE
				&& cmd_word < `DBESC_NUM_WORDS && cmd_bit != 4'h0
				&& (cmd_bit > 4'ha || i_io_profile)) begin
			sel_valid = 1'b1;
			sel_level = i_cmd_words[cmd_word * 15 + cmd_bit - 1];
		end
	end
	wire input_on = sel_valid && !i_mains_contactor_assigned;

	always @* begin
		case ({delay_on, input_on})
			2'b10:   o_mode = MODE_AUTO;
			2'b01:   o_mode = MODE_MANUAL;
			2'b11:   o_mode = MODE_SEMI;
			default: o_mode = MODE_OFF;
		endcase
	end

	reg  in_prev;
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n)
			in_prev <= 1'b0;
		else
			in_prev <= sel_level && input_on;
	end
	wire rise = input_on && sel_level && !in_prev;
	wire fall = input_on && !sel_level && in_prev;

	reg  [4:0]  state;
	reg  [14:0] sec_count;
	reg         clear_tick;
	wire        tick;

	dbesc_sec_tick u_tick (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (rst_n),
		.i_clear   (clear_tick),
		.o_tick    (tick)
	);

	reg [4:0] next_state;
	always @* begin
		next_state = state;
		clear_tick = 1'b0;
		case (state)
			ST_INIT: begin
				clear_tick = 1'b1;
				next_state = delay_on ? ST_SAVING : ST_NORMAL;
			end
			ST_NORMAL: begin
				if (delay_on && i_motor_stopped && !i_run_request) begin
					next_state = ST_DELAY;
					clear_tick = 1'b1;
				end else if (rise && i_motor_stopped && !i_run_request)
					next_state = ST_SAVING;
			end
			ST_DELAY: begin
				// falling edges fall through unchanged here
				if (i_run_request || !i_motor_stopped || !delay_on)
					next_state = ST_NORMAL;
				else if (rise)
					next_state = ST_SAVING;
				else if (sec_count >= delay_lim)
					next_state = ST_SAVING;
			end
			ST_SAVING: begin
				if (i_run_request) begin
					next_state = ST_EXIT;
					clear_tick = 1'b1;
				end else if (fall)
					next_state = ST_NORMAL;
			end
			ST_EXIT: begin
				if (i_bus_charged)
					next_state = ST_NORMAL;
				else if (sec_count >= {5'h00, tmo_lim})
					next_state = ST_SAVING;
			end
			default: next_state = ST_INIT;
		endcase
	end

	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state           <= ST_INIT;
			sec_count       <= 15'h0000;
			o_exit_error    <= 1'b0;
			o_energy_saving <= 1'b0;
			o_bus_charge_en <= 1'b0;
			o_run_enable    <= 1'b0;
		end else begin
			state <= next_state;
			if (clear_tick || next_state != state)
				sec_count <= 15'h0000;
			else if (tick && sec_count != 15'h7fff)
				sec_count <= sec_count + 15'h0001;
			if (state == ST_EXIT && next_state == ST_SAVING)
				o_exit_error <= 1'b1;
			else if (state == ST_EXIT && next_state == ST_NORMAL)
				o_exit_error <= 1'b0;
			// saving is also reported while the exit is still pending
			o_energy_saving <= next_state == ST_SAVING || next_state == ST_EXIT;
			o_bus_charge_en <= next_state != ST_SAVING && next_state != ST_INIT;
			// run waits for the bus; a bus charged early runs at once
			o_run_enable <= (next_state == ST_NORMAL || next_state == ST_DELAY)
				&& i_bus_charged && i_run_request;
		end
	end
endmodule // dbesc_ctrl

// *** verif/dbesc_drive_model.sv ***
// drive power stage: dc bus charges a few clocks after charge enable
// assumes charge enable from the controller, one control clock
`timescale 1ns/1ps
module dbesc_drive_model #(parameter LAT = 4) (
	input  wire i_ref_clk,
	input  wire i_charge_en,
	output reg  o_bus_charged
);
	reg [3:0] cnt = 4'h0;
	initial o_bus_charged = 1'b0;
	// source type left unconfigured: bus follows charge enable only
	always @(posedge i_ref_clk) begin
		cnt <= !i_charge_en ? 4'h0 : (cnt == LAT) ? cnt : cnt + 4'h1;
		o_bus_charged <= i_charge_en && (cnt == LAT);
	end
endmodule // dbesc_drive_model

// *** verif/dbesc_ctrl_asserts.sv ***
// checker on the ports of the energy saving controller
// assumes bind onto dbesc_ctrl, one clock domain
`timescale 1ns/1ps
module dbesc_ctrl_asserts (
	input logic       i_ref_clk,
	input logic       i_nrst,
	input logic       i_delay_en,
	input logic [6:0] i_saving_input_select,
	input logic       i_mains_contactor_assigned,
	input logic       i_motor_stopped,
	input logic       i_run_request,
	input logic       i_bus_charged,
	input logic       o_energy_saving,
	input logic       o_bus_charge_en,
	input logic       o_run_enable,
	input logic       o_exit_error,
	input logic [1:0] o_mode
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	charge_drop_a: assert property ($fell(o_bus_charge_en) |-> o_energy_saving)
		else $error("charge dropped outside saving");
	exit_charge_a: assert property (o_energy_saving && !o_bus_charge_en && i_run_request
		|=> o_bus_charge_en) else $error("run request did not charge bus");
	exit_done_a: assert property (o_energy_saving && o_bus_charge_en && i_bus_charged
		|=> !o_energy_saving) else $error("charged bus did not end saving");
	run_after_a: assert property (o_run_enable |-> !o_energy_saving)
		else $error("run enabled in saving");
	err_saving_a: assert property ($rose(o_exit_error) |-> o_energy_saving)
		else $error("exit error outside saving");
	mode_map_a: assert property (!i_mains_contactor_assigned && i_saving_input_select <= 7'h06
		|-> o_mode == {|i_saving_input_select, i_delay_en}) else $error("mode wrong");
	contactor_off_a: assert property (i_mains_contactor_assigned |-> o_mode == 2'h0)
		else $error("contactor did not force off");
	run_blocks_a: assert property (!o_energy_saving && o_bus_charge_en && !i_motor_stopped
		|=> !o_energy_saving) else $error("saving with motor running");
	cover property ($rose(o_energy_saving));
	cover property ($fell(o_energy_saving));
	cover property ($rose(o_run_enable));
endmodule // dbesc_ctrl_asserts
bind dbesc_ctrl dbesc_ctrl_asserts u_dbesc_ctrl_asserts (.*);

// *** verif/dbesc_ctrl_tb.sv ***
// testbench of the energy saving controller with a drive model
// assumes the design core and the checker compiled before it
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module dbesc_ctrl_tb;
	reg        clk = 0, nrst = 0, den = 0, mca = 0, run = 0, stp = 1, iop = 1;
	reg [14:0] dly = 15'h0000;
	reg  [6:0] sel = 7'h00;
	reg  [5:0] di = 6'h00;
	wire       bc, sav, ce, ren, err;
	wire [1:0] mode;
	int        err_total = 0, check_count = 0, cyc = 0;
	// {delay_en, contactor, select, mode}
	reg [10:0] rows [0:3] = '{11'h401, 11'h006, 11'h40f, 11'h604};
	dbesc_ctrl u_dbesc_ctrl (.i_ref_clk(clk), .i_nrst(nrst), .i_delay_en(den),
		.i_delay_s(dly), .i_saving_input_select(sel), .i_exit_timeout_s(10'h005),
		.i_mains_contactor_assigned(mca), .i_io_profile(iop),
		.i_physical_digital_input(di), .i_cmd_words(75'h0), .i_motor_stopped(stp),
		.i_run_request(run), .i_bus_charged(bc), .o_energy_saving(sav),
		.o_bus_charge_en(ce), .o_run_enable(ren), .o_exit_error(err), .o_mode(mode));
	dbesc_drive_model u_dbesc_drive_model (.i_ref_clk(clk), .i_charge_en(ce),
		.o_bus_charged(bc));
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			err_total++;
			stop_test;
		end
	end
	task stop_test;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task cy(input int n);
		repeat (n) @(negedge clk);
	endtask
	task rst(input logic d);
		@(negedge clk);
		nrst = 0;
		den = d;
		cy(12);
		nrst = 1;
		cy(6);
	endtask
	initial begin
		foreach (rows[i]) begin
			{den, mca, sel} = rows[i][10:2];
			@(negedge clk);
			`CHK(mode, rows[i][1:0])
		end
		mca = 0;
		den = 0;
		sel = 7'h09;
		iop = 0;
		cy(1);
		`CHK(mode, 2'h0)
		iop = 1;
		cy(1);
		`CHK(mode, 2'h2)
		sel = 7'h13;
		iop = 0;
		cy(1);
		`CHK(mode, 2'h2)
		iop = 1;
		sel = 7'h03;
		rst(1);
		`CHK({sav, ce}, 2'h2)
		run = 1;
		stp = 0;
		cy(1);
		`CHK({sav, ce}, 2'h3)
		cy(10);
		`CHK({sav, ren}, 2'h1)
		`CHK(err, 1'b0)
		run = 0;
		stp = 1;
		cy(4);
		`CHK(sav, 1'b1)
		sel = 7'h01;
		rst(0);
		`CHK({sav, ce}, 2'h1)
		run = 1;
		di = 6'h01;
		cy(2);
		`CHK(sav, 1'b0)
		di = 6'h00;
		run = 0;
		cy(2);
		di = 6'h01;
		cy(2);
		`CHK({sav, ce}, 2'h2)
		di = 6'h00;
		cy(10);
		`CHK({sav, ce}, 2'h1)
		run = 1;
		cy(2);
		`CHK(ren, 1'b1)
		// semi mode with a one second delay: edges while the delay counts
		den = 1;
		dly = 15'h0001;
		di = 6'h01;
		cy(2);
		`CHK({sav, ren}, 2'h1)
		run = 0;
		cy(2);
		`CHK({sav, ce}, 2'h1)
		di = 6'h00;
		cy(2);
		`CHK(sav, 1'b0)
		di = 6'h01;
		cy(2);
		`CHK({sav, ce}, 2'h2)
		stop_test;
	end
endmodule // dbesc_ctrl_tb
